// *** src/dpc_perf_counter.sv ***
// dual event performance counter with setup registers and monitor pins
`timescale 1ns/1ps
`default_nettype none

module dpc_perf_counter #(
  parameter int NUM_EVENTS = dpc_pkg::NUM_EVENTS,
  parameter int BUS_DIV    = dpc_pkg::BUS_DIV
) (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  // current privilege level and user read permit from control register four
  input  wire logic [1:0]             cpl_in,
  input  wire logic                   user_read_permit_in,
  // event sources, one group of sub-condition bits per event code
  input  wire logic [NUM_EVENTS-1:0][dpc_pkg::SUBCOND_W-1:0] event_bits_in,
  // model register read and write
  input  wire dpc_pkg::dpc_reg_req_t  reg_req_in,
  output logic                        reg_ack_out,
  output logic                        reg_fault_out,
  output logic [dpc_pkg::CNT_W-1:0]   reg_rdata_out,
  // counter read instruction
  input  wire logic                   pmc_req_in,
  input  wire logic                   pmc_sel_in,
  output logic                        pmc_ack_out,
  output logic                        pmc_fault_out,
  output logic [dpc_pkg::CNT_W-1:0]   pmc_rdata_out,
  // overflow interrupt request and monitor pins
  output logic                        perf_irq_out,
  output logic [1:0]                  monitor_pin_out
);
  import dpc_pkg::*;

  localparam int IDX_W = (NUM_EVENTS > 1) ? $clog2(NUM_EVENTS) : 1;
  localparam int DIV_W = (BUS_DIV > 1) ? $clog2(BUS_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BUS_DIV - 1);

  // ---------------------------------------------------------------
  // register access decode
  // ---------------------------------------------------------------
  logic        kernel_mode;
  logic        reg_ok;
  logic        reg_refused;
  logic        wr_ok;
  logic        wr_setup0;
  logic        wr_setup1;
  logic [39:0] wr_count_val;

  assign kernel_mode = (cpl_in == 2'h0);
  assign reg_ok      = reg_req_in.req & kernel_mode; // [RULE_16]
  assign reg_refused = reg_req_in.req & ~kernel_mode; // [RULE_16]
  assign wr_ok       = reg_ok & reg_req_in.write;
  assign wr_setup0   = wr_ok & (reg_req_in.sel == DPC_REG_SETUP0);
  assign wr_setup1   = wr_ok & (reg_req_in.sel == DPC_REG_SETUP1);
  // signed presets: top byte copies bit 31
  assign wr_count_val = {{(CNT_W-DATA_W){reg_req_in.wdata[SIGN_BIT]}},
                         reg_req_in.wdata}; // [RULE_15]

  // ---------------------------------------------------------------
  // setup registers
  // ---------------------------------------------------------------
  // the reserved bit, and the enable bit of the second word, read back as
  // zero so software cannot believe the second word gates anything alone
  logic [31:0] setup0_q;
  logic [31:0] setup1_q;
  dpc_setup_t  setup [2];

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      setup0_q <= SETUP_RESET;
      setup1_q <= SETUP_RESET;
    end else begin
      if (wr_setup0) begin
        setup0_q <= reg_req_in.wdata & SETUP0_WMASK;
      end
      if (wr_setup1) begin
        setup1_q <= reg_req_in.wdata & SETUP1_WMASK; // [RULE_11]
      end
    end
  end

  assign setup[0] = dpc_setup_t'(setup0_q);
  assign setup[1] = dpc_setup_t'(setup1_q);

  // ---------------------------------------------------------------
  // run enables
  // ---------------------------------------------------------------
  // enable takes effect the cycle after the write that sets it
  logic run [2];

  assign run[0] = setup[0].global_enable; // [RULE_11] [RULE_19] [RULE_20]
  assign run[1] = setup[0].global_enable & (setup1_q != SETUP_RESET); // [RULE_20]

  // ---------------------------------------------------------------
  // bus clock enable for the monitor pins
  // ---------------------------------------------------------------
  // the bus clock is a divided enable, so the pins stay in this domain
  logic [DIV_W-1:0] div_q;
  logic             bus_tick;

  assign bus_tick = (div_q == DIV_LAST);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_q <= '0;
    end else if (bus_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // counter channels
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] count_w [2];
  logic [1:0]       ovf_irq_w;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      localparam logic [1:0] CNT_IDX = 2'(int'(DPC_REG_COUNT0) + g);

      logic [SUBCOND_W-1:0] masked;
      logic [POP_W-1:0]     pop;
      logic [POP_W-1:0]     raw;
      logic                 is_dur;
      logic                 priv_ok;
      logic                 cmp;
      logic [POP_W-1:0]     qual_inc;
      logic                 active;
      logic [POP_W-1:0]     inc;
      logic [POP_W-1:0]     gated;
      logic [CNT_W:0]       sum;
      logic                 load;
      logic                 overflow;
      logic                 pin_event;
      logic [CNT_W-1:0]     cnt_q;
      logic                 prev_q;
      logic                 pend_q;
      logic                 pin_q;

      // event code picks the source, qualifier narrows it
      assign masked = event_bits_in[setup[g].event_code[IDX_W-1:0]] // [RULE_03]
                    & setup[g].qualifier_mask; // [RULE_04]

      always_comb begin
        pop = '0;
        for (int b = 0; b < SUBCOND_W; b++) begin
          pop = pop + POP_W'(masked[b]);
        end
      end

      // duration codes add one per clock while any qualified bit holds
      assign is_dur = setup[g].event_code[DUR_CODE_BIT];
      assign raw    = is_dur ? POP_W'(|masked) : pop; // [RULE_02]

      assign priv_ok = (kernel_mode & setup[g].kernel_level_flag)  // [RULE_06]
                     | (~kernel_mode & setup[g].user_level_flag); // [RULE_05]

      assign cmp = ({4'h0, raw} >= setup[g].threshold_field) // [RULE_13]
                 ^ setup[g].invert_flag; // [RULE_12]

      assign qual_inc = (setup[g].threshold_field != 8'h00)
                      ? POP_W'(cmp) // [RULE_13]
                      : raw; // [RULE_14]

      // edge mode sees the privilege and enable gating as well
      assign active = (qual_inc != '0) & priv_ok & run[g];
      assign inc    = setup[g].edge_flag ? POP_W'(active & ~prev_q) // [RULE_07]
                                         : qual_inc;
      assign gated  = (priv_ok & run[g]) ? inc : '0;

      assign sum      = {1'b0, cnt_q} + {{(CNT_W+1-POP_W){1'b0}}, gated};
      assign load     = wr_ok & (reg_req_in.sel == dpc_reg_t'(CNT_IDX));
      assign overflow = sum[CNT_W] & ~load; // [RULE_21]
      assign pin_event = setup[g].pin_mode_flag ? (gated != '0) : overflow; // [RULE_08]

      always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
          cnt_q  <= COUNT_RESET;
          prev_q <= 1'b0;
        end else begin
          prev_q <= active;
          if (load) begin
            cnt_q <= wr_count_val; // [RULE_15]
          end else begin
            cnt_q <= sum[CNT_W-1:0]; // [RULE_01] [RULE_21]
          end
        end
      end

      // pending pulse waits for a bus clock; a new event beats the clear
      always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
          pend_q <= 1'b0;
          pin_q  <= 1'b0;
        end else begin
          if (bus_tick) begin
            if (pin_q) begin
              pin_q <= 1'b0; // [RULE_09]
            end else if (pend_q) begin
              pin_q <= 1'b1; // [RULE_09]
            end
          end
          if (pin_event) begin
            pend_q <= 1'b1;
          end else if (bus_tick & ~pin_q & pend_q) begin
            pend_q <= 1'b0;
          end
        end
      end

      assign count_w[g]         = cnt_q;
      assign ovf_irq_w[g]       = overflow & setup[g].overflow_int_flag; // [RULE_10]
      assign monitor_pin_out[g] = pin_q;
    end
  endgenerate

  // ---------------------------------------------------------------
  // read data selection
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] reg_rd_sel;
  logic             pmc_ok;
  logic [CNT_W-1:0] pmc_rd_sel;

  assign reg_rd_sel =
      (reg_req_in.sel == DPC_REG_SETUP0) ? {8'h00, setup0_q} :
      (reg_req_in.sel == DPC_REG_SETUP1) ? {8'h00, setup1_q} :
      (reg_req_in.sel == DPC_REG_COUNT0) ? count_w[0] : count_w[1];

  // user reads pass only with the permit set
  assign pmc_ok     = pmc_req_in & (kernel_mode | user_read_permit_in); // [RULE_17]
  assign pmc_rd_sel = pmc_sel_in ? count_w[1] : count_w[0];

  // ---------------------------------------------------------------
  // answer registers
  // ---------------------------------------------------------------
  logic             reg_ack_q;
  logic             reg_fault_q;
  logic [CNT_W-1:0] reg_rdata_q;
  logic [CNT_W-1:0] reg_rdata_d;
  logic             reg_rd_grant;
  logic             pmc_ack_q;
  logic             pmc_fault_q;
  logic             pmc_fault_d;
  logic [CNT_W-1:0] pmc_rdata_q;
  logic [CNT_W-1:0] pmc_rdata_d;
  logic             irq_q;
  logic             irq_d;

  // refused reads and all writes answer zero, so no stale word leaks to
  // a level that may not see it; idle cycles keep the last answer
  assign reg_rd_grant = reg_ok & ~reg_req_in.write;
  assign reg_rdata_d  = reg_rd_grant   ? reg_rd_sel  :
                        reg_req_in.req ? COUNT_RESET : reg_rdata_q;

  // sampled the cycle it is asked, with no ordering against other traffic:
  // a read racing an event may see the count one step short
  assign pmc_fault_d  = pmc_req_in & ~pmc_ok; // [RULE_17]
  assign pmc_rdata_d  = pmc_ok     ? pmc_rd_sel  : // [RULE_18]
                        pmc_req_in ? COUNT_RESET : pmc_rdata_q;

  // both channels overflowing in one cycle give a single request pulse
  assign irq_d = |ovf_irq_w; // [RULE_10]

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_ack_q   <= 1'b0;
      reg_fault_q <= 1'b0;
      reg_rdata_q <= COUNT_RESET;
    end else begin
      reg_ack_q   <= reg_req_in.req;
      reg_fault_q <= reg_refused; // [RULE_16]
      reg_rdata_q <= reg_rdata_d;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pmc_ack_q   <= 1'b0;
      pmc_fault_q <= 1'b0;
      pmc_rdata_q <= COUNT_RESET;
    end else begin
      pmc_ack_q   <= pmc_req_in; // [RULE_18]
      pmc_fault_q <= pmc_fault_d; // [RULE_17]
      pmc_rdata_q <= pmc_rdata_d;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d; // [RULE_10]
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_ack_out   = reg_ack_q;
  assign reg_fault_out = reg_fault_q;
  assign reg_rdata_out = reg_rdata_q;
  assign pmc_ack_out   = pmc_ack_q;
  assign pmc_fault_out = pmc_fault_q;
  assign pmc_rdata_out = pmc_rdata_q;
  assign perf_irq_out  = irq_q;

endmodule // dpc_perf_counter

`default_nettype wire

// *** src/dpc_pkg.sv ***
// constants, register map and field layout of the dual event counter block
//
// Function
// [RULE_01] two independent 40-bit counters count events or durations
// [RULE_02] duration mode adds one per clock while the condition holds
// [RULE_03] setup bits 7:0 pick the event source for the counter
// [RULE_04] setup bits 15:8 qualify the chosen event into a condition
// [RULE_05] bit 16 counts at privilege levels 1, 2 and 3
// [RULE_06] bit 17 counts at privilege level 0; both bits count always
// [RULE_07] bit 18 counts rising transitions only; back-to-back merges
// [RULE_08] bit 19 pulses pin per increment, else per overflow; code pulses once per cycle that adds, and pending pulses merge
// [RULE_09] each pin pulse is high for exactly one bus clock
// [RULE_10] bit 20 raises interrupt request on counter overflow
// [RULE_11] bit 22 of first setup only enables or halts both counters
// [RULE_12] bit 23 inverts the threshold comparison result
// [RULE_13] nonzero threshold adds one when cycle count reaches threshold
// [RULE_14] zero threshold adds the full per-cycle event count
// [RULE_15] counter write loads low 32 bits, sign-extends bit 31 upward
// [RULE_16] register read and write only at privilege level 0
// [RULE_17] counter read allowed anywhere if permit set, else level 0
// [RULE_18] counter read samples at once, no wait for other work
// [RULE_19] counting starts after the write that sets global enable
// [RULE_20] enable clear or zero setups stop; zero second setup stops it
// [RULE_21] overflow is carry out of top bit; counting goes on from zero
package dpc_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int CNT_W      = 40;
  localparam int DATA_W     = 32;
  localparam int SIGN_BIT   = 31;
  localparam int SUBCOND_W  = 8;
  localparam int POP_W      = 4;
  localparam int NUM_EVENTS = 4;
  localparam int BUS_DIV    = 2;

  // ---------------------------------------------------------------
  // register map and reset values
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DPC_REG_SETUP0 = 2'h0,
    DPC_REG_SETUP1 = 2'h1,
    DPC_REG_COUNT0 = 2'h2,
    DPC_REG_COUNT1 = 2'h3
  } dpc_reg_t;

  localparam logic [31:0] SETUP_RESET  = 32'h0000_0000;
  localparam logic [39:0] COUNT_RESET  = 40'h00_0000_0000;
  localparam logic [31:0] SETUP0_WMASK = 32'hFFDF_FFFF;
  localparam logic [31:0] SETUP1_WMASK = 32'hFF9F_FFFF;
  localparam int          DUR_CODE_BIT = 7;

  // setup word, msb first so that a cast puts each field at its bit
  typedef struct packed {
    logic [7:0] threshold_field;
    logic       invert_flag;
    logic       global_enable;
    logic       reserved;
    logic       overflow_int_flag;
    logic       pin_mode_flag;
    logic       edge_flag;
    logic       kernel_level_flag;
    logic       user_level_flag;
    logic [7:0] qualifier_mask;
    logic [7:0] event_code;
  } dpc_setup_t;

  // register request from the core
  typedef struct packed {
    logic        req;
    logic        write;
    dpc_reg_t    sel;
    logic [31:0] wdata;
  } dpc_reg_req_t;

endpackage : dpc_pkg

// *** testbench/dpc_core_model.sv ***
// core model: issues register and counter read requests, counts interrupts
`timescale 1ns/1ps
`default_nettype none
module dpc_core_model (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // answers from the counter block
  input  wire logic             reg_ack_in,
  input  wire logic             pmc_ack_in,
  input  wire logic             perf_irq_in,
  // requests and interrupt tally
  output var dpc_pkg::dpc_reg_req_t reg_req_out,
  output var logic              pmc_req_out,
  output var logic              pmc_sel_out,
  output var logic [7:0]        irq_count_out
);
  import dpc_pkg::*;
  initial begin
    reg_req_out = '0;
    pmc_req_out = 1'b0;
    pmc_sel_out = 1'b0;
  end
  // idle write and data fields carry the inverse so stale values cannot pass
  task automatic reg_acc(input logic w, input dpc_reg_t s, input logic [31:0] d);
    int n;
    repeat ($urandom % 3) @(posedge clk_in);
    @(posedge clk_in);
    reg_req_out <= '{1'b1, w, s, d};
    @(posedge clk_in);
    reg_req_out <= '{1'b0, ~w, s, ~d};
    n = 0;
    while (reg_ack_in !== 1'b1 && n < 8) begin
      @(posedge clk_in);
      n++;
    end
  endtask
  task automatic pmc_rd(input logic s);
    int n;
    @(posedge clk_in);
    pmc_req_out <= 1'b1;
    pmc_sel_out <= s;
    @(posedge clk_in);
    pmc_req_out <= 1'b0;
    pmc_sel_out <= ~s;
    n = 0;
    while (pmc_ack_in !== 1'b1 && n < 8) begin
      @(posedge clk_in);
      n++;
    end
  endtask
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) irq_count_out <= 8'h00;
    else if (perf_irq_in) irq_count_out <= irq_count_out + 8'h01;
  end
endmodule // dpc_core_model
`default_nettype wire

// *** testbench/dpc_perf_counter_assertions.sv ***
// checker for register, counter read and pin timing
`timescale 1ns/1ps
`default_nettype none
module dpc_perf_counter_assertions #(
  parameter int BUS_DIV = 2
) (
  input wire logic                  clk_in,
  input wire logic                  reset_in,
  input wire logic [1:0]            cpl_in,
  input wire logic                  user_read_permit_in,
  input wire dpc_pkg::dpc_reg_req_t reg_req_in,
  input wire logic                  reg_ack_out,
  input wire logic                  reg_fault_out,
  input wire logic [39:0]           reg_rdata_out,
  input wire logic                  pmc_req_in,
  input wire logic                  pmc_ack_out,
  input wire logic                  pmc_fault_out,
  input wire logic [39:0]           pmc_rdata_out,
  input wire logic [1:0]            monitor_pin_out
);
  import dpc_pkg::*;
  // ---------------------------------------------------------------
  // pin high-time counters
  // ---------------------------------------------------------------
  logic [7:0] hc0_q;
  logic [7:0] hc1_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      hc0_q <= 8'h00;
      hc1_q <= 8'h00;
    end else begin
      hc0_q <= monitor_pin_out[0] ? hc0_q + 8'h01 : 8'h00;
      hc1_q <= monitor_pin_out[1] ? hc1_q + 8'h01 : 8'h00;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_reg_ok;
    reg_req_in.req && cpl_in == 2'h0;
  endsequence
  sequence s_reg_bad;
    reg_req_in.req && cpl_in != 2'h0;
  endsequence
  sequence s_pmc_ok;
    pmc_req_in && (cpl_in == 2'h0 || user_read_permit_in);
  endsequence
  a_reg_ack_next: assert property (reg_req_in.req |=> reg_ack_out)
    else $error("register access not answered");
  a_reg_ack_idle: assert property (!reg_req_in.req |=> !reg_ack_out)
    else $error("register answer without access");
  a_reg_refused: assert property (s_reg_bad |=> reg_fault_out && reg_rdata_out == '0)
    else $error("user level register access not refused");
  a_reg_granted: assert property (s_reg_ok |=> !reg_fault_out)
    else $error("kernel level register access refused");
  a_pmc_refused: assert property (pmc_req_in && cpl_in != 2'h0 && !user_read_permit_in
    |=> pmc_fault_out && pmc_rdata_out == '0) else $error("counter read not refused");
  a_pmc_granted: assert property (s_pmc_ok |=> pmc_ack_out && !pmc_fault_out)
    else $error("counter read not granted");
  a_pmc_hold: assert property (!pmc_req_in |=> $stable(pmc_rdata_out))
    else $error("counter read data changed without request");
  a_pin_width0: assert property ($fell(monitor_pin_out[0]) |-> hc0_q == 8'(BUS_DIV))
    else $error("pin 0 pulse width wrong");
  a_pin_width1: assert property ($fell(monitor_pin_out[1]) |-> hc1_q == 8'(BUS_DIV))
    else $error("pin 1 pulse width wrong");
endmodule // dpc_perf_counter_assertions
bind dpc_perf_counter dpc_perf_counter_assertions #(.BUS_DIV(BUS_DIV)) u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .cpl_in(cpl_in),
  .user_read_permit_in(user_read_permit_in), .reg_req_in(reg_req_in),
  .reg_ack_out(reg_ack_out), .reg_fault_out(reg_fault_out), .reg_rdata_out(reg_rdata_out),
  .pmc_req_in(pmc_req_in), .pmc_ack_out(pmc_ack_out), .pmc_fault_out(pmc_fault_out),
  .pmc_rdata_out(pmc_rdata_out), .monitor_pin_out(monitor_pin_out));
`default_nettype wire

// *** testbench/dpc_perf_counter_tb.sv ***
// self-checking bench for the dual event counter block
`timescale 1ns/1ps
`default_nettype none
module dpc_perf_counter_tb;
  import dpc_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in, permit, reg_ack, reg_fault, pmc_ack, pmc_fault, irq, pmc_req, pmc_sel;
  logic [1:0] cpl, pin, p0;
  logic [NUM_EVENTS-1:0][SUBCOND_W-1:0] ev;
  dpc_reg_req_t req;
  logic [CNT_W-1:0] reg_rd, pmc_rd;
  logic [7:0] irq_cnt, i0, n0, npin;
  logic [31:0] r;
  logic [40:0] q_reg[$], q_pmc[$];
  int miscompares = 0, n_tests = 0;
  always #50 clk_in = ~clk_in;
  dpc_perf_counter u_dpc_perf_counter (.clk_in(clk_in), .reset_in(reset_in), .cpl_in(cpl),
    .user_read_permit_in(permit), .event_bits_in(ev), .reg_req_in(req), .reg_ack_out(reg_ack),
    .reg_fault_out(reg_fault), .reg_rdata_out(reg_rd), .pmc_req_in(pmc_req),
    .pmc_sel_in(pmc_sel), .pmc_ack_out(pmc_ack), .pmc_fault_out(pmc_fault),
    .pmc_rdata_out(pmc_rd), .perf_irq_out(irq), .monitor_pin_out(pin));
  dpc_core_model u_dpc_core_model (.clk_in(clk_in), .reset_in(reset_in), .reg_ack_in(reg_ack),
    .pmc_ack_in(pmc_ack), .perf_irq_in(irq), .reg_req_out(req), .pmc_req_out(pmc_req),
    .pmc_sel_out(pmc_sel), .irq_count_out(irq_cnt));
  task automatic chk(input string nm, input logic [40:0] e, input logic [40:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic acc(input logic w, input dpc_reg_t s, input logic [31:0] d, input logic [40:0] e);
    q_reg.push_back(e);
    u_dpc_core_model.reg_acc(w, s, d);
  endtask
  task automatic pmc(input logic s, input logic [40:0] e);
    q_pmc.push_back(e);
    u_dpc_core_model.pmc_rd(s);
  endtask
  // ---------------------------------------------------------------
  // one counting window on a random source, then read the total
  // ---------------------------------------------------------------
  task automatic run(input logic g, input logic [31:0] s, input logic [1:0] c,
                     input logic [7:0] e, input int n, input logic [31:0] pre,
                     input logic [39:0] x);
    int idx;
    logic [31:0] sw;
    logic [NUM_EVENTS-1:0][SUBCOND_W-1:0] vv;
    idx = $urandom % NUM_EVENTS;
    sw = s | 32'(idx);
    for (int i = 0; i < NUM_EVENTS; i++) vv[i] = 8'($urandom);
    vv[idx] = e;
    // setups first: a stale random setup must not count past the preset
    acc(1'b1, DPC_REG_SETUP1, g ? sw : 32'h0, 41'h0);
    acc(1'b1, DPC_REG_SETUP0, g ? 32'h0040_0000 : sw, 41'h0);
    acc(1'b1, g ? DPC_REG_COUNT1 : DPC_REG_COUNT0, pre, 41'h0);
    @(posedge clk_in);
    cpl <= c;
    ev <= vv;
    repeat (n) @(posedge clk_in);
    cpl <= 2'h0;
    ev <= '0;
    acc(1'b0, g ? DPC_REG_COUNT1 : DPC_REG_COUNT0, 32'h0, {1'b0, x});
  endtask
  always @(posedge clk_in) begin
    if (reg_ack === 1'b1)
      chk("reg", q_reg.size() ? q_reg.pop_front() : 'x, {reg_fault, reg_rd});
    if (pmc_ack === 1'b1)
      chk("pmc", q_pmc.size() ? q_pmc.pop_front() : 'x, {pmc_fault, pmc_rd});
    npin <= npin + 8'((pin[0] === 1'b1) && (p0[0] !== 1'b1))
                 + 8'((pin[1] === 1'b1) && (p0[1] !== 1'b1));
    p0 <= pin;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    print_verdict();
  end
  initial begin
    reset_in = 1'b1;
    cpl = 2'h0;
    permit = 1'b0;
    ev = '0;
    npin = 8'h00;
    void'($urandom(32'h99BAB86C));
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 4; i++) acc(1'b0, dpc_reg_t'(i), 32'h0, 41'h0);
    for (int i = 2; i < 4; i++) begin
      r = $urandom;
      acc(1'b1, dpc_reg_t'(i), r, 41'h0);
      acc(1'b0, dpc_reg_t'(i), 32'h0, {1'b0, {8{r[31]}}, r});
    end
    @(posedge clk_in) cpl <= 2'h1;
    acc(1'b1, DPC_REG_COUNT1, 32'h0, {1'b1, 40'h0});
    @(posedge clk_in) cpl <= 2'h3;
    pmc(1'b1, {1'b1, 40'h0});
    @(posedge clk_in) permit <= 1'b1;
    pmc(1'b1, {1'b0, {8{r[31]}}, r});
    @(posedge clk_in) cpl <= 2'h0;
    r = $urandom;
    acc(1'b1, DPC_REG_SETUP0, r, 41'h0);
    acc(1'b0, DPC_REG_SETUP0, 32'h0, {9'h0, r & SETUP0_WMASK});
    acc(1'b1, DPC_REG_SETUP1, ~r, 41'h0);
    acc(1'b0, DPC_REG_SETUP1, 32'h0, {9'h0, ~r & SETUP1_WMASK});
    run(1'b0, 32'h0041_FF00, 2'h3, 8'h0F, 5, 32'h0, 40'h14);
    run(1'b0, 32'h0041_0300, 2'h3, 8'h0F, 5, 32'h0, 40'h0A);
    run(1'b0, 32'h0341_FF00, 2'h3, 8'h0F, 5, 32'h0, 40'h05);
    run(1'b0, 32'h03C1_FF00, 2'h3, 8'h03, 5, 32'h0, 40'h05);
    run(1'b0, 32'h0041_FF80, 2'h3, 8'h0F, 5, 32'h0, 40'h05);
    run(1'b0, 32'h0045_FF00, 2'h3, 8'h0F, 5, 32'h0, 40'h01);
    run(1'b0, 32'h0042_FF00, 2'h3, 8'h0F, 5, 32'h0, 40'h00);
    run(1'b0, 32'h0042_FF00, 2'h0, 8'h0F, 5, 32'h0, 40'h14);
    run(1'b0, 32'h0001_FF00, 2'h3, 8'h0F, 5, 32'h0, 40'h00);
    n0 = npin;
    run(1'b1, 32'h0049_FF00, 2'h3, 8'h0F, 1, 32'h0, 40'h04);
    repeat (8) @(posedge clk_in);
    chk("pin", 41'(n0 + 8'h01), 41'(npin));
    run(1'b1, 32'h0000_0000, 2'h3, 8'h0F, 3, 32'h0, 40'h00);
    i0 = irq_cnt;
    n0 = npin;
    run(1'b0, 32'h0051_FF00, 2'h3, 8'h01, 3, 32'hFFFF_FFFE, 40'h01);
    repeat (8) @(posedge clk_in);
    chk("irq", 41'(i0 + 8'h01), 41'(irq_cnt));
    chk("pin", 41'(n0 + 8'h01), 41'(npin));
    n0 = npin;
    run(1'b0, 32'h0049_FF00, 2'h3, 8'h01, 1, 32'h0, 40'h01);
    repeat (8) @(posedge clk_in);
    chk("pin", 41'(n0 + 8'h01), 41'(npin));
    @(posedge clk_in) cpl <= 2'h3;
    pmc(1'b0, {1'b0, 40'h01});
    repeat (4) @(posedge clk_in);
    chk("queue", 41'h0, 41'(q_reg.size() + q_pmc.size()));
    print_verdict();
  end
endmodule // dpc_perf_counter_tb
`default_nettype wire
